// [ldcr_pkg.sv]
// ============================================================
// Configuration register bank constants
package ldcr_pkg;

  // ==========================================================
  // Host port and mode keys
  localparam logic       LDCR_SEL_INDEX   = 1'b0;
  localparam logic       LDCR_SEL_DATA    = 1'b1;
  localparam logic [7:0] LDCR_KEY_ENTER   = 8'h55;
  localparam logic [7:0] LDCR_KEY_EXIT    = 8'hAA;

  // ==========================================================
  // Global register range
  localparam logic [7:0] LDCR_GLB_LAST    = 8'h2F;
  localparam logic [7:0] LDCR_GLB_CTRL    = 8'h02;
  localparam logic [7:0] LDCR_GLB_LDNUM   = 8'h07;
  localparam int         LDCR_SOFT_BIT    = 0;
  localparam int         LDCR_ENABLE_BIT  = 0;
  localparam logic [7:0] LDCR_ZERO        = 8'h00;

  // ==========================================================
  // Power-up lockout timing
  localparam int LDCR_CLK_MHZ       = 100;
  localparam int LDCR_POR_BLOCK_US  = 500;
  localparam int LDCR_POR_BLOCK_CYC = LDCR_POR_BLOCK_US * LDCR_CLK_MHZ;

  // ==========================================================
  // Logical device numbers
  localparam logic [7:0] LDCR_LD_SER1 = 8'h04;
  localparam logic [7:0] LDCR_LD_SER2 = 8'h05;
  localparam logic [7:0] LDCR_LD_KBD  = 8'h07;
  localparam logic [7:0] LDCR_LD_AUX  = 8'h08;
  localparam logic [7:0] LDCR_LD_RTR  = 8'h0A;
  localparam logic [7:0] LDCR_LD_MIDI = 8'h0B;

  // ==========================================================
  // Reset source flags: {soft, standby por, main por, bus}
  localparam logic [3:0] LDCR_SRC_ALL  = 4'hF;
  localparam logic [3:0] LDCR_SRC_HARD = 4'h7;
  localparam logic [3:0] LDCR_SRC_VTR  = 4'h4;
  localparam int LDCR_SRC_BUS  = 0;
  localparam int LDCR_SRC_VCC  = 1;
  localparam int LDCR_SRC_STBY = 2;
  localparam int LDCR_SRC_SOFT = 3;

  // ==========================================================
  // Register table
  localparam int LDCR_NREG = 27;
  localparam int LDCR_NACT = 6;

  localparam logic [7:0] LDCR_REG_LD [LDCR_NREG] = '{
    LDCR_LD_SER1, LDCR_LD_SER1, LDCR_LD_SER1, LDCR_LD_SER1, LDCR_LD_SER1,
    LDCR_LD_SER2, LDCR_LD_SER2, LDCR_LD_SER2, LDCR_LD_SER2, LDCR_LD_SER2,
    LDCR_LD_SER2, LDCR_LD_SER2,
    LDCR_LD_KBD,  LDCR_LD_KBD,  LDCR_LD_KBD,  LDCR_LD_KBD,
    LDCR_LD_AUX,  LDCR_LD_AUX,  LDCR_LD_AUX,
    LDCR_LD_RTR,  LDCR_LD_RTR,  LDCR_LD_RTR,  LDCR_LD_RTR,
    LDCR_LD_MIDI, LDCR_LD_MIDI, LDCR_LD_MIDI, LDCR_LD_MIDI};

  localparam logic [7:0] LDCR_REG_IDX [LDCR_NREG] = '{
    8'h30, 8'h60, 8'h61, 8'h70, 8'hF0,
    8'h30, 8'h60, 8'h61, 8'h70, 8'hF0, 8'hF1, 8'hF2,
    8'h30, 8'h70, 8'h72, 8'hF0,
    8'h30, 8'h60, 8'h61,
    8'h30, 8'h60, 8'h61, 8'hF0,
    8'h30, 8'h60, 8'h61, 8'h70};

  localparam logic [7:0] LDCR_REG_RST [LDCR_NREG] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h03,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h03, 8'h30, 8'h05};

  localparam logic [3:0] LDCR_REG_SRC [LDCR_NREG] = '{
    LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_HARD,
    LDCR_SRC_VTR, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_HARD,
    LDCR_SRC_HARD, LDCR_SRC_HARD,
    LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_HARD,
    LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL,
    LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_VTR,
    LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL, LDCR_SRC_ALL};

  // Bits kept through bus and main-supply resets (standby only)
  localparam logic [7:0] LDCR_KBD_STBY_BITS = 8'h60;
  localparam int         LDCR_E_KBD_GATE    = 15;

  // Entry numbers used by status outputs and checks
  localparam int LDCR_E_SER1_ACT  = 0;
  localparam int LDCR_E_SER1_BASE = 1;
  localparam int LDCR_E_SER1_MODE = 4;
  localparam int LDCR_E_SER2_MODE = 9;
  localparam int LDCR_E_IR_TMO    = 11;
  localparam int LDCR_E_KBD_IRQ   = 13;
  localparam int LDCR_E_MOUSE_IRQ = 14;
  localparam int LDCR_E_MIDI_BH   = 24;
  localparam int LDCR_E_MIDI_BL   = 25;

  localparam int LDCR_ACT_ENTRY [LDCR_NACT] = '{0, 5, 12, 16, 19, 23};

endpackage : ldcr_pkg

// [ldcr_reg_if.sv]
`timescale 1ns/10ps
// ============================================================
// Carrier between the bank control and one stored register
interface ldcr_reg_if;
  logic       we;
  logic [7:0] wdata;
  logic       rst_bus;
  logic       rst_vcc;
  logic       rst_stby;
  logic       rst_soft;
  logic [7:0] q;

  modport ctrl  (output we, wdata, rst_bus, rst_vcc, rst_stby, rst_soft,
                 input  q);
  modport store (input  we, wdata, rst_bus, rst_vcc, rst_stby, rst_soft,
                 output q);
endinterface : ldcr_reg_if

// [ldcr_cfg_reg.sv]
`timescale 1ns/10ps
// ============================================================
// One 8-bit configuration register with per-source defaults
module ldcr_cfg_reg
  import ldcr_pkg::*;
#(
  parameter logic [7:0] RST_VAL   = 8'h00,
  parameter logic [3:0] RST_SRC   = 4'hF,
  parameter logic [7:0] STBY_ONLY = 8'h00
) (
  input wire logic    core_clk,
  ldcr_reg_if.store   rif
);

  logic [7:0] q_q;
  logic [7:0] keep_d;

  // Bits owned by the standby reset survive the other sources
  assign keep_d = (RST_VAL & ~STBY_ONLY) | (q_q & STBY_ONLY);

  // Standby reset outranks hard resets, which outrank soft reset
  always_ff @(posedge core_clk) begin
    if (rif.rst_stby && RST_SRC[LDCR_SRC_STBY]) begin
      q_q <= RST_VAL;
    end else if ((rif.rst_bus && RST_SRC[LDCR_SRC_BUS]) ||
                 (rif.rst_vcc && RST_SRC[LDCR_SRC_VCC])) begin
      q_q <= keep_d;
    end else if (rif.rst_soft && RST_SRC[LDCR_SRC_SOFT]) begin
      q_q <= keep_d;
    end else if (rif.we) begin
      q_q <= rif.wdata;
    end
  end

  assign rif.q = q_q;

endmodule : ldcr_cfg_reg

// [ldcr_bank.sv]
`timescale 1ns/10ps
// Operation
// - Host writes a register number to index port; data port then uses it.
// - Data port reads and writes act on the last selected register.
// - Registers reachable only in configuration mode.
// - Selection compares all eight index bits, no aliasing.
// - Unimplemented registers ignore writes, read zero; implemented ones store all eight bits.
// - Reserved registers are read-only and read zero.
// - Keyboard gate register bits 6:5 clear only on standby power-on reset.
// - Indexes 0x00 to 0x2F select global registers shared by all devices.
// - Serial one mode clears on bus and power-on resets, keeps on soft.
// - Serial two mode clears on bus and power-on resets, keeps on soft.
// - Infrared timeout defaults to three on hard resets, keeps on soft.
// - Keyboard interrupt select at 0x70, zero on every reset.
// - Mouse interrupt select at 0x72, zero on every reset.
// - Keyboard gate register clears on bus and power-on except bits 6:5 (standby only), keeps on soft.
// - MIDI base defaults to 0x03 and 0x30 on every reset.
// - Base address bytes 0x60 and 0x61 clear on every reset source, except MIDI's.
// - Writing 0xAA to the configuration port returns to run state.
// - Setting control register bit 0 triggers soft reset defaults.
// - Bus reset pin loads the bus reset defaults.
// - All host accesses blocked 500 us after main power-on reset; a bus or standby reset ends the block early.
module ldcr_bank
  import ldcr_pkg::*;
#(
  parameter int BLOCK_CYCLES = LDCR_POR_BLOCK_CYC
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset,
  input  wire logic                    main_power_on_reset,
  input  wire logic                    standby_power_on_reset,
  input  wire logic                    io_wr,
  input  wire logic                    io_rd,
  input  wire logic                    io_sel,
  input  wire logic [7:0]              io_wdata,
  output logic      [7:0]              io_rdata,
  output logic                         io_rd_valid,
  output logic                         config_mode,
  output logic                         host_blocked,
  output logic      [LDCR_NACT-1:0]    device_enable,
  output logic      [LDCR_NREG*8-1:0]  cfg_regs
);

  typedef enum logic {LDCR_RUN, LDCR_CONFIG} ldcr_mode_t;

  // ==========================================================
  // Power-on reset pin synchronisers
  logic       vcc_meta_q;
  logic       vcc_sync_q;
  logic       stby_meta_q;
  logic       stby_sync_q;

  // Two stages each; only the second stage is used below
  always_ff @(posedge core_clk) begin
    vcc_meta_q  <= main_power_on_reset;
    vcc_sync_q  <= vcc_meta_q;
    stby_meta_q <= standby_power_on_reset;
    stby_sync_q <= stby_meta_q;
  end

  logic hard_rst;
  assign hard_rst = reset || vcc_sync_q || stby_sync_q;

  // ==========================================================
  // Host lockout after main-supply power-on
  logic [31:0] block_cnt_q;
  logic        blocked;

  // Counter is held loaded during the reset, cleared by bus or standby reset, else runs down
  always_ff @(posedge core_clk) begin
    if (vcc_sync_q) begin
      block_cnt_q <= 32'(BLOCK_CYCLES);
    end else if (reset || stby_sync_q) begin
      block_cnt_q <= '0;
    end else if (block_cnt_q != '0) begin
      block_cnt_q <= block_cnt_q - 32'd1;
    end
  end

  assign blocked = vcc_sync_q || (block_cnt_q != '0);

  logic acc_wr;
  logic acc_rd;
  assign acc_wr = io_wr && !blocked;
  assign acc_rd = io_rd && !blocked;

  // ==========================================================
  // Mode, index and logical device number
  ldcr_mode_t mode_q;
  logic [7:0] index_q;
  logic [7:0] ldnum_q;
  logic       soft_q;
  logic       idx_wr;
  logic       dat_wr;
  logic       dat_rd;

  assign idx_wr = acc_wr && (io_sel == LDCR_SEL_INDEX);
  assign dat_wr = acc_wr && (io_sel == LDCR_SEL_DATA) &&
                  (mode_q == LDCR_CONFIG);
  assign dat_rd = acc_rd && (io_sel == LDCR_SEL_DATA) &&
                  (mode_q == LDCR_CONFIG);

  // Entry key is honoured only in run state, exit key only in config
  always_ff @(posedge core_clk) begin
    if (hard_rst) begin
      mode_q <= LDCR_RUN;
    end else if (idx_wr) begin
      case (mode_q)
        LDCR_RUN: begin
          if (io_wdata == LDCR_KEY_ENTER) begin
            mode_q <= LDCR_CONFIG;
          end
        end
        LDCR_CONFIG: begin
          if (io_wdata == LDCR_KEY_EXIT) begin
            mode_q <= LDCR_RUN;
          end
        end
        default: begin
          mode_q <= LDCR_RUN;
        end
      endcase
    end
  end

  // Index latches on any index write in config except the exit key
  always_ff @(posedge core_clk) begin
    if (hard_rst) begin
      index_q <= LDCR_ZERO;
    end else if (idx_wr && (mode_q == LDCR_CONFIG) &&
                 (io_wdata != LDCR_KEY_EXIT)) begin
      index_q <= io_wdata;
    end
  end

  // Device number register lives in the global range
  always_ff @(posedge core_clk) begin
    if (hard_rst || soft_q) begin
      ldnum_q <= LDCR_ZERO;
    end else if (dat_wr && (index_q == LDCR_GLB_LDNUM)) begin
      ldnum_q <= io_wdata;
    end
  end

  // Control register is write-only; bit 0 fires a one-cycle soft reset
  always_ff @(posedge core_clk) begin
    if (hard_rst) begin
      soft_q <= 1'b0;
    end else begin
      soft_q <= dat_wr && (index_q == LDCR_GLB_CTRL) &&
                io_wdata[LDCR_SOFT_BIT];
    end
  end

  // ==========================================================
  // Register storage and decode
  logic                     is_global;
  logic [7:0]               reg_val [LDCR_NREG];
  logic [LDCR_NREG-1:0]     hit;
  logic [LDCR_NREG*8-1:0]   rd_terms;

  assign is_global = (index_q <= LDCR_GLB_LAST);

  ldcr_reg_if rif [LDCR_NREG] ();

  genvar g;
  generate
    for (g = 0; g < LDCR_NREG; g++) begin : g_reg
      // Full-width match on both device number and index
      assign hit[g] = !is_global && (ldnum_q == LDCR_REG_LD[g]) &&
                      (index_q == LDCR_REG_IDX[g]);
      assign rif[g].we       = dat_wr && hit[g];
      assign rif[g].wdata    = io_wdata;
      assign rif[g].rst_bus  = reset;
      assign rif[g].rst_vcc  = vcc_sync_q;
      assign rif[g].rst_stby = stby_sync_q;
      assign rif[g].rst_soft = soft_q;
      assign reg_val[g]      = rif[g].q;
      assign rd_terms[g*8 +: 8] = hit[g] ? rif[g].q : LDCR_ZERO;
      assign cfg_regs[g*8 +: 8] = rif[g].q;

      // Defaults per source; keyboard gate bits 6:5 standby-only
      ldcr_cfg_reg #(
        .RST_VAL   (LDCR_REG_RST[g]),
        .RST_SRC   (LDCR_REG_SRC[g]),
        .STBY_ONLY ((g == LDCR_E_KBD_GATE) ? LDCR_KBD_STBY_BITS
                                           : LDCR_ZERO)
      ) u_reg (
        .core_clk (core_clk),
        .rif      (rif[g].store)
      );
    end

    for (g = 0; g < LDCR_NACT; g++) begin : g_act
      assign device_enable[g] =
        reg_val[LDCR_ACT_ENTRY[g]][LDCR_ENABLE_BIT];
    end
  endgenerate

  // ==========================================================
  // Read path
  logic [7:0] rd_mux;

  // Unmatched or reserved indexes fall through as zero
  always_comb begin
    rd_mux = LDCR_ZERO;
    if (is_global) begin
      if (index_q == LDCR_GLB_LDNUM) begin
        rd_mux = ldnum_q;
      end
    end else begin
      for (int k = 0; k < LDCR_NREG; k++) begin
        rd_mux = rd_mux | rd_terms[k*8 +: 8];
      end
    end
  end

  // Reads answer one cycle later; blocked or run-state reads give zero
  always_ff @(posedge core_clk) begin
    if (hard_rst) begin
      io_rdata    <= LDCR_ZERO;
      io_rd_valid <= 1'b0;
    end else begin
      io_rd_valid <= io_rd;
      if (dat_rd) begin
        io_rdata <= rd_mux;
      end else if (io_rd) begin
        io_rdata <= LDCR_ZERO;
      end
    end
  end

  assign config_mode  = (mode_q == LDCR_CONFIG);
  assign host_blocked = blocked;

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_cfg_data_wr;
    !blocked && io_wr && io_sel && config_mode;
  endsequence

  sequence s_soft_fire;
    soft_q && !vcc_sync_q && !stby_sync_q;
  endsequence

  a_exit_cfg_mode: assert property (
    config_mode && idx_wr && io_wdata == LDCR_KEY_EXIT |=> !config_mode)
    else $error("exit key did not leave config mode");

  a_run_no_write: assert property (
    !config_mode && io_wr && io_sel && !vcc_sync_q && !stby_sync_q
    && !soft_q |=> $stable(cfg_regs))
    else $error("data write reached registers in run state");

  a_index_capture: assert property (
    config_mode && idx_wr && io_wdata != LDCR_KEY_EXIT && !vcc_sync_q
    && !stby_sync_q |=> index_q == $past(io_wdata))
    else $error("index port value not captured");

  a_data_write: assert property (
    s_cfg_data_wr ##0 (hit[LDCR_E_SER1_ACT] && !hard_rst && !soft_q)
    |=> reg_val[LDCR_E_SER1_ACT] == $past(io_wdata))
    else $error("data write missed selected register");

  a_unmapped_zero: assert property (
    dat_rd && hit == '0 && index_q != LDCR_GLB_LDNUM && !hard_rst
    |=> io_rd_valid && io_rdata == LDCR_ZERO)
    else $error("unmapped read not zero");

  a_block_after_por: assert property (
    $fell(vcc_sync_q) && !reset |-> host_blocked [*8])
    else $error("host access open too soon after power-on");

  a_soft_keeps_mode: assert property (
    s_soft_fire ##0 !dat_wr |=> reg_val[LDCR_E_SER1_MODE] ==
                    $past(reg_val[LDCR_E_SER1_MODE]) &&
                    reg_val[LDCR_E_SER2_MODE] ==
                    $past(reg_val[LDCR_E_SER2_MODE]))
    else $error("soft reset disturbed serial mode");

  a_soft_midi_base: assert property (
    s_soft_fire |=> reg_val[LDCR_E_MIDI_BH] == LDCR_REG_RST[LDCR_E_MIDI_BH]
                && reg_val[LDCR_E_MIDI_BL] == LDCR_REG_RST[LDCR_E_MIDI_BL])
    else $error("midi base not defaulted by soft reset");

  a_soft_irq_clear: assert property (
    s_soft_fire |=> reg_val[LDCR_E_KBD_IRQ] == LDCR_ZERO &&
                    reg_val[LDCR_E_MOUSE_IRQ] == LDCR_ZERO)
    else $error("input interrupt selects not cleared");

  a_global_zero: assert property (
    dat_rd && is_global && index_q != LDCR_GLB_LDNUM && !hard_rst
    |=> io_rdata == LDCR_ZERO)
    else $error("global range read not zero");

  a_soft_base_clear: assert property (
    s_soft_fire |=> reg_val[LDCR_E_SER1_BASE] == LDCR_ZERO ##1
                    $stable(reg_val[LDCR_E_SER1_BASE]) || $past(dat_wr))
    else $error("base address not cleared by soft reset");

  a_kbd_gate_hold: assert property (
    @(posedge core_clk) disable iff (stby_sync_q)
    reset && !stby_sync_q |=> reg_val[LDCR_E_KBD_GATE][6:5] ==
                              $past(reg_val[LDCR_E_KBD_GATE][6:5]))
    else $error("gate bits 6:5 changed on bus reset");

  a_ir_timeout_dflt: assert property (
    @(posedge core_clk) disable iff (1'b0)
    reset && !stby_sync_q |=> reg_val[LDCR_E_IR_TMO] ==
                              LDCR_REG_RST[LDCR_E_IR_TMO])
    else $error("infrared timeout not defaulted");

  // Hard-reset defaults; no disable, since the reset itself is watched
  a_bus_rst_mode: assert property (
    @(posedge core_clk) disable iff (1'b0)
    reset |=> reg_val[LDCR_E_SER2_MODE] == LDCR_ZERO &&
              reg_val[LDCR_E_SER1_MODE] == LDCR_ZERO)
    else $error("serial mode not cleared by bus reset");

  a_gate_hard_clear: assert property (
    @(posedge core_clk) disable iff (1'b0)
    reset |=> (reg_val[LDCR_E_KBD_GATE] & ~LDCR_KBD_STBY_BITS) == LDCR_ZERO)
    else $error("gate register not cleared by bus reset");

  a_bus_rst_base: assert property (
    @(posedge core_clk) disable iff (1'b0)
    reset |=> reg_val[LDCR_E_SER1_BASE] == LDCR_ZERO &&
              reg_val[LDCR_E_MIDI_BH] == LDCR_REG_RST[LDCR_E_MIDI_BH])
    else $error("base address not defaulted by bus reset");

  a_rst_run_state: assert property (
    @(posedge core_clk) disable iff (1'b0)
    hard_rst |=> !config_mode)
    else $error("reset did not return to run state");

  a_read_answer: assert property (
    io_rd && !hard_rst |=> io_rd_valid)
    else $error("read strobe got no answer");

endmodule : ldcr_bank

// [ldcr_host_model.sv]
`timescale 1ns/10ps
// ============================================================
// Host side of the index and data configuration ports
module ldcr_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] io_rdata,
  input  wire logic       io_rd_valid,
  output logic            io_wr,
  output logic            io_rd,
  output logic            io_sel,
  output logic      [7:0] io_wdata
);
  // Idle bus at time zero
  initial begin
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_sel   = 1'b0;
    io_wdata = 8'h00;
  end

  // One write strobe: an index byte picks a register, a data byte fills it
  // Idle data is inverted so a stale byte never passes for a fresh one
  task automatic wr(input logic sel, input logic [7:0] data);
    @(posedge core_clk);
    io_wr    <= 1'b1;
    io_sel   <= sel;
    io_wdata <= data;
    @(posedge core_clk);
    io_wr    <= 1'b0;
    io_sel   <= ~sel;
    io_wdata <= ~data;
  endtask : wr

  // One read strobe; the answer is taken exactly one edge later
  task automatic rd(input logic sel, output logic [7:0] data,
                    output logic vld);
    @(posedge core_clk);
    io_rd  <= 1'b1;
    io_sel <= sel;
    @(posedge core_clk);
    io_rd  <= 1'b0;
    io_sel <= ~sel;
    @(posedge core_clk);
    data = io_rdata;
    vld  = io_rd_valid;
  endtask : rd
endmodule : ldcr_host_model

// [tb.sv]
`timescale 1ns/10ps
// ============================================================
// Register bank testbench
module tb;
  import ldcr_pkg::*;
  localparam int BLK = 20;

  logic                   core_clk = 1'b0;
  logic                   reset    = 1'b1;
  logic                   mpor     = 1'b0;
  logic                   spor     = 1'b1;
  logic                   io_wr;
  logic                   io_rd;
  logic                   io_sel;
  logic [7:0]             io_wdata;
  logic [7:0]             io_rdata;
  logic                   io_rd_valid;
  logic                   config_mode;
  logic                   host_blocked;
  logic [LDCR_NACT-1:0]   device_enable;
  logic [LDCR_NREG*8-1:0] cfg_regs;
  logic [7:0]             exp_regs [LDCR_NREG];
  int                     miscompares = 0;
  int                     checks_done = 0;
  int                     cyc = 0;

  always #5 core_clk = ~core_clk;

  ldcr_bank #(.BLOCK_CYCLES(BLK)) ldcr_bank_inst (
    .core_clk(core_clk), .reset(reset), .main_power_on_reset(mpor),
    .standby_power_on_reset(spor), .io_wr(io_wr), .io_rd(io_rd),
    .io_sel(io_sel), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rd_valid(io_rd_valid), .config_mode(config_mode),
    .host_blocked(host_blocked), .device_enable(device_enable),
    .cfg_regs(cfg_regs));

  ldcr_host_model ldcr_host_model_inst (
    .core_clk(core_clk), .io_rdata(io_rdata), .io_rd_valid(io_rd_valid),
    .io_wr(io_wr), .io_rd(io_rd), .io_sel(io_sel), .io_wdata(io_wdata));

  // ==========================================================
  // Reporting
  task automatic results;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", what, e, g);
      miscompares++;
    end
  endtask : chk

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  // ==========================================================
  // Host helpers
  task automatic w(input logic sel, input logic [7:0] d);
    ldcr_host_model_inst.wr(sel, d);
  endtask : w

  task automatic rdv(output logic [7:0] d);
    logic ok;
    ldcr_host_model_inst.rd(LDCR_SEL_DATA, d, ok);
    chk("rd_valid", 8'h01, {7'h00, ok});
  endtask : rdv

  task automatic sel(input logic [7:0] ld, input logic [7:0] idx);
    w(LDCR_SEL_INDEX, LDCR_GLB_LDNUM);
    w(LDCR_SEL_DATA, ld);
    w(LDCR_SEL_INDEX, idx);
  endtask : sel

  task automatic check_all;
    logic [7:0] v;
    for (int k = 0; k < LDCR_NREG; k++) begin
      sel(LDCR_REG_LD[k], LDCR_REG_IDX[k]);
      rdv(v);
      chk("reg_read", exp_regs[k], v);
      chk("cfg_regs", exp_regs[k], cfg_regs[k*8+:8]);
    end
    for (int i = 0; i < LDCR_NACT; i++) begin
      chk("enable", {7'h00, exp_regs[LDCR_ACT_ENTRY[i]][LDCR_ENABLE_BIT]},
          {7'h00, device_enable[i]});
    end
  endtask : check_all

  // Distinct byte per register; keyboard gate gets bits 6:5 set
  task automatic fill;
    for (int k = 0; k < LDCR_NREG; k++) begin
      sel(LDCR_REG_LD[k], LDCR_REG_IDX[k]);
      exp_regs[k] = 8'h7E ^ 8'(k);
      w(LDCR_SEL_DATA, exp_regs[k]);
    end
  endtask : fill

  // Expected contents after one reset source
  task automatic apply_rst(input int src);
    for (int k = 0; k < LDCR_NREG; k++) begin
      if (LDCR_REG_SRC[k][src]) begin
        if (k == LDCR_E_KBD_GATE && src != LDCR_SRC_STBY) begin
          exp_regs[k] = (exp_regs[k] & LDCR_KBD_STBY_BITS) |
                        (LDCR_REG_RST[k] & ~LDCR_KBD_STBY_BITS);
        end else begin
          exp_regs[k] = LDCR_REG_RST[k];
        end
      end
    end
  endtask : apply_rst

  // ==========================================================
  // Scenarios
  task automatic t_run;
    logic [7:0] v;
    chk("config_mode", 8'h00, {7'h00, config_mode});
    w(LDCR_SEL_INDEX, 8'h30);
    w(LDCR_SEL_DATA, 8'hFF);
    rdv(v);
    chk("run_read", 8'h00, v);
    w(LDCR_SEL_INDEX, LDCR_KEY_ENTER);
    @(posedge core_clk);
    chk("config_mode", 8'h01, {7'h00, config_mode});
    check_all();
  endtask : t_run

  // Aliased, unmapped, reserved and global places, then exit and return
  task automatic t_access;
    logic [7:0] v;
    fill();
    check_all();
    sel(LDCR_LD_SER1, 8'h31);
    w(LDCR_SEL_DATA, 8'hFF);
    rdv(v);
    chk("unmapped", 8'h00, v);
    sel(LDCR_LD_SER1, 8'hB0);
    rdv(v);
    chk("alias", 8'h00, v);
    sel(LDCR_LD_SER1, 8'h03);
    w(LDCR_SEL_DATA, 8'hFF);
    rdv(v);
    chk("reserved", 8'h00, v);
    w(LDCR_SEL_INDEX, LDCR_GLB_LDNUM);
    rdv(v);
    chk("global", LDCR_LD_SER1, v);
    w(LDCR_SEL_INDEX, LDCR_KEY_EXIT);
    @(posedge core_clk);
    chk("config_mode", 8'h00, {7'h00, config_mode});
    w(LDCR_SEL_DATA, 8'h00);
    w(LDCR_SEL_INDEX, LDCR_KEY_ENTER);
    rdv(v);
    chk("run_data", LDCR_LD_SER1, v);
    check_all();
  endtask : t_access

  task automatic t_soft;
    w(LDCR_SEL_INDEX, LDCR_GLB_CTRL);
    w(LDCR_SEL_DATA, 8'h01);
    apply_rst(LDCR_SRC_SOFT);
    check_all();
  endtask : t_soft

  task automatic t_bus;
    fill();
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apply_rst(LDCR_SRC_BUS);
    chk("config_mode", 8'h00, {7'h00, config_mode});
    w(LDCR_SEL_INDEX, LDCR_KEY_ENTER);
    check_all();
  endtask : t_bus

  // Lockout: entry attempt while blocked must be lost
  task automatic t_por;
    int cnt;
    fill();
    @(posedge core_clk);
    mpor <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("blocked", 8'h01, {7'h00, host_blocked});
    mpor <= 1'b0;
    w(LDCR_SEL_INDEX, LDCR_KEY_ENTER);
    cnt = 2;
    while (host_blocked === 1'b1 && cnt < 200) begin
      @(posedge core_clk);
      cnt++;
    end
    chk("config_mode", 8'h00, {7'h00, config_mode});
    checks_done++;
    if (cnt < BLK || cnt > BLK + 5) begin
      $display("Error block_len expected %0d seen %0d", BLK, cnt);
      miscompares++;
    end
    apply_rst(LDCR_SRC_VCC);
    w(LDCR_SEL_INDEX, LDCR_KEY_ENTER);
    check_all();
  endtask : t_por

  task automatic t_stby;
    fill();
    @(posedge core_clk);
    spor <= 1'b1;
    repeat (4) @(posedge core_clk);
    spor <= 1'b0;
    repeat (4) @(posedge core_clk);
    apply_rst(LDCR_SRC_STBY);
    w(LDCR_SEL_INDEX, LDCR_KEY_ENTER);
    check_all();
  endtask : t_stby

  // ==========================================================
  // Main sequence: both resets held three cycles to load every default
  initial begin
    foreach (exp_regs[k]) exp_regs[k] = LDCR_REG_RST[k];
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    spor  <= 1'b0;
    repeat (4) @(posedge core_clk);
    t_run();
    t_access();
    t_soft();
    t_bus();
    t_por();
    t_stby();
    results();
  end
endmodule : tb
